//--- hdl/iam_addr_match.v
// i2c target address recognition, ack and spike filter for the led driver
`timescale 1ns/1ps
`default_nettype none
`include "iam_map.vh"
// How it works
// (RULE1) address byte follows start; its last bit is direction, 1 read, 0 write
// (RULE2) three four-level straps select one of 64 regular addresses, 40h..BEh; the code's nibble table gives 20h..EEh, with gaps
// (RULE3) master avoids reserved codes as target addresses
// (RULE4) group-call address resets to 90h, rewritable, volatile
// (RULE5) group call enabled at reset; 90h and 91h acknowledged
// (RULE6) master never uses default group-call value as a regular address
// (RULE7) three sub-call addresses reset to 92h, 94h, 98h, rewritable
// (RULE8) sub-call matching disabled at reset; defaults not acknowledged
// (RULE9) master may reuse sub-call defaults while their enables stay cleared
// (RULE10) soft-reset call acknowledged only with write direction
// (RULE11) master never programs soft-reset call value into any address
// (RULE12) pulses on clock and data shorter than 50 ns are ignored
// (RULE13) system avoids reset pin assertion during a transfer
// (RULE14) group call answered only while its enable is set; enable resets to 1
// (RULE15) byte after any accepted address loads the control pointer; the code loads it only after a write-direction address other than soft reset
// (RULE16) accepted soft-reset call restores every register like power-on; the code restores only the call addresses and enables
// (RULE17) ack on regular, write-direction soft-reset or enabled group/sub match; otherwise release data
module iam_addr_match (
   input wire core_clk_i,
   input wire reset_n_i,
   input wire scl_i,
   input wire sda_i,
   output reg sda_o,
   output reg sda_oe_o,
   input wire [1:0] strap_pin_low_i,
   input wire [1:0] strap_pin_mid_i,
   input wire [1:0] strap_pin_high_i,
   input wire cfg_wr_i,
   input wire [2:0] cfg_sel_i,
   input wire [7:0] cfg_wdata_i,
   output reg [7:0] group_call_address_reg_o,
   output reg [7:0] sub_call_address_first_o,
   output reg [7:0] sub_call_address_second_o,
   output reg [7:0] sub_call_address_third_o,
   output reg [3:0] sub_call_enables_o,
   output reg [6:0] regular_addr_o,
   output reg [2:0] match_kind_o,
   output reg read_dir_o,
   output reg [7:0] ctrl_ptr_o,
   output reg ctrl_ptr_vld_o,
   output reg [7:0] data_byte_o,
   output reg data_byte_vld_o,
   output reg soft_reset_call_o
);

   localparam ST_IDLE = 3'h0;
   localparam ST_ADDR = 3'h1;
   localparam ST_AACK = 3'h2;
   localparam ST_CTRL = 3'h3;
   localparam ST_DATA = 3'h4;
   localparam ST_DACK = 3'h5;
   localparam integer FILT_SPAN = `IAM_FILT_CYC - 1;
   localparam [1:0] FILT_LAST = FILT_SPAN[1:0]; // two bits cover the sample window
   ////////////////////////////////////////////////////////////////////////
   // bus line synchronisers and spike filters, bit 0 scl, bit 1 sda
   wire [1:0] line_raw;
   wire [1:0] line_filt;
   assign line_raw = {sda_i, scl_i};

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_filt
         reg meta_r;
         reg sync_r;
         reg filt_r;
         reg [1:0] cnt_r;
         assign line_filt[gi] = filt_r; // per-line stages keep one driver per register
         // a new level must hold for every sample of the window
         always @(posedge core_clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
               meta_r <= 1'b1;
               sync_r <= 1'b1;
               filt_r <= 1'b1;
               cnt_r <= 2'h0;
            end else begin
               meta_r <= line_raw[gi];
               sync_r <= meta_r;
               if (sync_r == filt_r) begin
                  cnt_r <= 2'h0; // spike ended, restart the window
               end else if (cnt_r == FILT_LAST) begin
                  filt_r <= sync_r; // RULE12
                  cnt_r <= 2'h0;
               end else begin
                  cnt_r <= cnt_r + 2'h1;
               end
            end
         end
      end
   endgenerate
   reg [1:0] line_prev_r;
   wire scl_f, sda_f, scl_rise, scl_fall, start_cond, stop_cond;
   assign scl_f = line_filt[0];
   assign sda_f = line_filt[1];
   assign scl_rise = scl_f & ~line_prev_r[0];
   assign scl_fall = ~scl_f & line_prev_r[0];
   assign start_cond = scl_f & line_prev_r[0] & ~sda_f & line_prev_r[1];
   assign stop_cond = scl_f & line_prev_r[0] & sda_f & ~line_prev_r[1];

   ////////////////////////////////////////////////////////////////////////
   // strap synchronisers; straps are static but still come from pins
   reg [5:0] strap_meta_r;
   reg [5:0] strap_sync_r;
   always @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         strap_meta_r <= 6'h00;
         strap_sync_r <= 6'h00;
      end else begin
         strap_meta_r <= {strap_pin_high_i, strap_pin_mid_i, strap_pin_low_i};
         strap_sync_r <= strap_meta_r;
      end
   end

   // bus-tied straps pick the upper nibble, vcc/sda pick each low bit
   reg [3:0] addr_hi;
   always @* begin
      case ({strap_sync_r[5], strap_sync_r[3], strap_sync_r[1]})
         3'h0: addr_hi = `IAM_HI_000;
         3'h1: addr_hi = `IAM_HI_001;
         3'h2: addr_hi = `IAM_HI_010;
         3'h3: addr_hi = `IAM_HI_011;
         3'h4: addr_hi = `IAM_HI_100;
         3'h5: addr_hi = `IAM_HI_101;
         3'h6: addr_hi = `IAM_HI_110;
         default: addr_hi = `IAM_HI_111;
      endcase
   end
   wire [6:0] regular_addr_nxt;
   assign regular_addr_nxt = {addr_hi, strap_sync_r[4], strap_sync_r[2], strap_sync_r[0]}; // RULE2
   ////////////////////////////////////////////////////////////////////////
   // address compare on the assembled byte
   reg [7:0] shift_r;
   wire [6:0] rx_addr;
   wire rx_read;
   wire hit_soft, hit_reg, hit_group, hit_sub1, hit_sub2, hit_sub3;
   assign rx_addr = shift_r[7:1];
   assign rx_read = shift_r[0]; // RULE1
   // soft reset is ignored with the read direction
   assign hit_soft = (rx_addr == `IAM_SOFT_RESET_ADDR) & ~rx_read; // RULE10
   assign hit_reg = (rx_addr == regular_addr_o);
   assign hit_group = sub_call_enables_o[`IAM_EN_GROUP_BIT] &
      (rx_addr == group_call_address_reg_o[7:1]); // RULE5 RULE14
   assign hit_sub1 = sub_call_enables_o[`IAM_EN_SUB1_BIT] & (rx_addr == sub_call_address_first_o[7:1]); // RULE8
   assign hit_sub2 = sub_call_enables_o[`IAM_EN_SUB2_BIT] & (rx_addr == sub_call_address_second_o[7:1]);
   assign hit_sub3 = sub_call_enables_o[`IAM_EN_SUB3_BIT] & (rx_addr == sub_call_address_third_o[7:1]);

   reg [2:0] kind_nxt;
   always @* begin
      if (hit_soft) begin
         kind_nxt = `IAM_KIND_SOFT;
      end else if (hit_reg) begin
         kind_nxt = `IAM_KIND_REGULAR; // RULE17
      end else if (hit_group) begin
         kind_nxt = `IAM_KIND_GROUP;
      end else if (hit_sub1) begin
         kind_nxt = `IAM_KIND_SUB1;
      end else if (hit_sub2) begin
         kind_nxt = `IAM_KIND_SUB2;
      end else if (hit_sub3) begin
         kind_nxt = `IAM_KIND_SUB3;
      end else begin
         kind_nxt = `IAM_KIND_NONE;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // protocol state machine; ack is driven from one scl fall to the next
   reg [2:0] state_r;
   reg [3:0] bit_cnt_r;
   reg soft_pending_r;
   always @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_r <= ST_IDLE;
         bit_cnt_r <= 4'h0;
         shift_r <= 8'h00;
         line_prev_r <= 2'h3;
         soft_pending_r <= 1'b0;
         sda_o <= 1'b0;
         sda_oe_o <= 1'b0;
         regular_addr_o <= 7'h00;
         match_kind_o <= `IAM_KIND_NONE;
         read_dir_o <= 1'b0;
         ctrl_ptr_o <= 8'h00;
         ctrl_ptr_vld_o <= 1'b0;
         data_byte_o <= 8'h00;
         data_byte_vld_o <= 1'b0;
         soft_reset_call_o <= 1'b0;
      end else begin
         line_prev_r <= line_filt;
         regular_addr_o <= regular_addr_nxt;
         sda_o <= 1'b0; // open drain, only the enable toggles
         ctrl_ptr_vld_o <= 1'b0;
         data_byte_vld_o <= 1'b0;
         soft_reset_call_o <= 1'b0;
         if (start_cond) begin
            // repeated start also lands here, abandoning any byte
            state_r <= ST_ADDR; // RULE1
            bit_cnt_r <= 4'h0;
            sda_oe_o <= 1'b0;
         end else if (stop_cond) begin
            state_r <= ST_IDLE;
            sda_oe_o <= 1'b0;
         end else begin
            if (scl_rise && bit_cnt_r != 4'h8 &&
                (state_r == ST_ADDR || state_r == ST_CTRL || state_r == ST_DATA)) begin
               shift_r <= {shift_r[6:0], sda_f};
               bit_cnt_r <= bit_cnt_r + 4'h1;
            end
            if (scl_fall) begin
               case (state_r)
                  ST_ADDR: begin
                     if (bit_cnt_r == 4'h8) begin
                        if (kind_nxt != `IAM_KIND_NONE) begin
                           sda_oe_o <= 1'b1; // RULE17
                           state_r <= ST_AACK;
                           match_kind_o <= kind_nxt;
                           read_dir_o <= rx_read;
                           soft_pending_r <= hit_soft;
                        end else begin
                           state_r <= ST_IDLE; // data line left released
                        end
                     end
                  end
                  ST_AACK: begin
                     sda_oe_o <= 1'b0;
                     bit_cnt_r <= 4'h0;
                     if (soft_pending_r) begin
                        soft_reset_call_o <= 1'b1; // RULE16
                        soft_pending_r <= 1'b0;
                        state_r <= ST_IDLE;
                     end else if (read_dir_o) begin
                        state_r <= ST_IDLE; // read data is served elsewhere
                     end else begin
                        state_r <= ST_CTRL;
                     end
                  end
                  ST_CTRL: begin
                     if (bit_cnt_r == 4'h8) begin
                        ctrl_ptr_o <= shift_r; // RULE15
                        ctrl_ptr_vld_o <= 1'b1;
                        sda_oe_o <= 1'b1;
                        state_r <= ST_DACK;
                     end
                  end
                  ST_DATA: begin
                     if (bit_cnt_r == 4'h8) begin
                        data_byte_o <= shift_r;
                        data_byte_vld_o <= 1'b1;
                        sda_oe_o <= 1'b1;
                        state_r <= ST_DACK;
                     end
                  end
                  ST_DACK: begin
                     sda_oe_o <= 1'b0;
                     bit_cnt_r <= 4'h0;
                     state_r <= ST_DATA;
                  end
                  default: begin
                     state_r <= ST_IDLE;
                  end
               endcase
            end
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // volatile address and enable registers; soft reset beats a write
   always @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         group_call_address_reg_o <= `IAM_GROUP_RST; // RULE4
         sub_call_address_first_o <= `IAM_SUB1_RST; // RULE7
         sub_call_address_second_o <= `IAM_SUB2_RST;
         sub_call_address_third_o <= `IAM_SUB3_RST;
         sub_call_enables_o <= `IAM_EN_RST; // RULE5 RULE8 RULE14
      end else if (soft_reset_call_o) begin
         group_call_address_reg_o <= `IAM_GROUP_RST; // RULE16
         sub_call_address_first_o <= `IAM_SUB1_RST;
         sub_call_address_second_o <= `IAM_SUB2_RST;
         sub_call_address_third_o <= `IAM_SUB3_RST;
         sub_call_enables_o <= `IAM_EN_RST;
      end else if (cfg_wr_i) begin
         case (cfg_sel_i)
            `IAM_SEL_GROUP: group_call_address_reg_o <= cfg_wdata_i; // RULE4
            `IAM_SEL_SUB1: sub_call_address_first_o <= cfg_wdata_i; // RULE7
            `IAM_SEL_SUB2: sub_call_address_second_o <= cfg_wdata_i;
            `IAM_SEL_SUB3: sub_call_address_third_o <= cfg_wdata_i;
            `IAM_SEL_EN: sub_call_enables_o <= cfg_wdata_i[3:0]; // RULE14
            default: sub_call_enables_o <= sub_call_enables_o;
         endcase
      end
   end

endmodule // iam_addr_match
`default_nettype wire

//--- hdl/iam_map.vh
// constants for the i2c address-match front end
`ifndef IAM_MAP_VH
`define IAM_MAP_VH

// timing
`define IAM_CLK_PERIOD_NS 25
`define IAM_SPIKE_NS 50
// samples a level must hold before it is believed
`define IAM_FILT_CYC (`IAM_SPIKE_NS / `IAM_CLK_PERIOD_NS + 1)

// address reset values (8-bit byte form, direction bit zero)
`define IAM_GROUP_RST 8'h90
`define IAM_SUB1_RST 8'h92
`define IAM_SUB2_RST 8'h94
`define IAM_SUB3_RST 8'h98
// enable bits: [3] sub1, [2] sub2, [1] sub3, [0] group
`define IAM_EN_RST 4'h1
`define IAM_EN_SUB1_BIT 3
`define IAM_EN_SUB2_BIT 2
`define IAM_EN_SUB3_BIT 1
`define IAM_EN_GROUP_BIT 0
// seven-bit soft-reset call address
`define IAM_SOFT_RESET_ADDR 7'h03

// configuration write selectors
`define IAM_SEL_GROUP 3'h0
`define IAM_SEL_SUB1 3'h1
`define IAM_SEL_SUB2 3'h2
`define IAM_SEL_SUB3 3'h3
`define IAM_SEL_EN 3'h4

// strap level codes
`define IAM_STRAP_GND 2'h0
`define IAM_STRAP_VCC 2'h1
`define IAM_STRAP_SCL 2'h2
`define IAM_STRAP_SDA 2'h3

// upper address nibble by {high,mid,low} tied to a bus line
`define IAM_HI_000 4'h4
`define IAM_HI_001 4'h5
`define IAM_HI_010 4'h2
`define IAM_HI_011 4'h3
`define IAM_HI_100 4'hC
`define IAM_HI_101 4'hE
`define IAM_HI_110 4'hA
`define IAM_HI_111 4'hB

// match kinds reported after an accepted address
`define IAM_KIND_NONE 3'h0
`define IAM_KIND_REGULAR 3'h1
`define IAM_KIND_GROUP 3'h2
`define IAM_KIND_SUB1 3'h3
`define IAM_KIND_SUB2 3'h4
`define IAM_KIND_SUB3 3'h5
`define IAM_KIND_SOFT 3'h6

`endif

//--- testbench/iam_addr_match_properties.sv
// port assertions for the i2c address matcher
`timescale 1ns/1ps
`default_nettype none
`include "iam_map.vh"
module iam_addr_match_properties (
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic sda_oe_o,
   input wire logic cfg_wr_i,
   input wire logic [2:0] cfg_sel_i,
   input wire logic [7:0] cfg_wdata_i,
   input wire logic [7:0] group_call_address_reg_o,
   input wire logic [7:0] sub_call_address_first_o,
   input wire logic [3:0] sub_call_enables_o,
   input wire logic [2:0] match_kind_o,
   input wire logic ctrl_ptr_vld_o,
   input wire logic soft_reset_call_o
);
   default clocking @(posedge core_clk_i);
   endclocking
   default disable iff (!reset_n_i);
   ////////////////////////////////////////////////////////////
   // defaults seen at the first edge out of reset
   reset_values_a: assert property ($rose(reset_n_i) |->
      group_call_address_reg_o == `IAM_GROUP_RST && sub_call_address_first_o == `IAM_SUB1_RST
      && sub_call_enables_o == `IAM_EN_RST) else $error("bad reset value");
   // a config write lands one edge later unless a soft reset call wins
   group_write_a: assert property (cfg_wr_i && cfg_sel_i == `IAM_SEL_GROUP && !soft_reset_call_o
      |=> group_call_address_reg_o == $past(cfg_wdata_i)) else $error("group write lost");
   enable_write_a: assert property (cfg_wr_i && cfg_sel_i == `IAM_SEL_EN && !soft_reset_call_o
      |=> sub_call_enables_o == $past(cfg_wdata_i[3:0])) else $error("enable write lost");
   // soft reset call restores the group address and the enables
   soft_restore_a: assert property (soft_reset_call_o |-> ##[1:2]
      (group_call_address_reg_o == `IAM_GROUP_RST && sub_call_enables_o == `IAM_EN_RST)) else $error("no restore");
   // ack only on a recognised address, group call only while enabled
   ack_has_match_a: assert property ($rose(sda_oe_o) |-> match_kind_o != `IAM_KIND_NONE)
      else $error("ack without match");
   group_gated_a: assert property ($rose(sda_oe_o) && match_kind_o == `IAM_KIND_GROUP
      |-> sub_call_enables_o[`IAM_EN_GROUP_BIT]) else $error("group ack while disabled");
   // ack must outlast a filter span; the pointer byte is acked
   ack_stands_a: assert property ($rose(sda_oe_o) |-> sda_oe_o [*8]) else $error("ack too short");
   ptr_acked_a: assert property (ctrl_ptr_vld_o |-> ##[0:2] sda_oe_o) else $error("pointer not acked");
   cover property (soft_reset_call_o);
   cover property (ctrl_ptr_vld_o);
   cover property ($rose(sda_oe_o) && match_kind_o == `IAM_KIND_GROUP);
endmodule // iam_addr_match_properties
bind iam_addr_match iam_addr_match_properties i_props (.core_clk_i, .reset_n_i, .sda_oe_o, .cfg_wr_i,
   .cfg_sel_i, .cfg_wdata_i, .group_call_address_reg_o, .sub_call_address_first_o, .sub_call_enables_o,
   .match_kind_o, .ctrl_ptr_vld_o, .soft_reset_call_o);
`default_nettype wire

//--- testbench/iam_bus_master.sv
// bus controller model driving clock and data of the two-wire link
`timescale 1ns/1ps
`default_nettype none
module iam_bus_master (
   output var logic scl_o,
   output var logic sda_low_o,
   input wire logic sda_i
);
   localparam int Q = 100;
   ////////////////////////////////////////////////////////////
   // both lines released at idle; clock stands still between frames
   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end
   // start: data falls while clock high
   task automatic start();
      #Q sda_low_o = 1'b1;
      #(2*Q) scl_o = 1'b0;
   endtask
   // msb first; low phase stretched past the responder's filter delay
   task automatic send_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         #Q sda_low_o = ~b[i];
         #(2*Q) scl_o = 1'b1;
         #(2*Q) scl_o = 1'b0;
      end
      #Q sda_low_o = 1'b0;
      #(2*Q) scl_o = 1'b1;
      #Q ack = ~sda_i;
      #Q scl_o = 1'b0;
   endtask
   // stop: data rises while clock high, then bus free time
   task automatic stop();
      #Q sda_low_o = 1'b1;
      #(2*Q) scl_o = 1'b1;
      #(2*Q) sda_low_o = 1'b0;
      #(4*Q);
   endtask
   // clock spike in the low phase, shorter than the filter span
   task automatic spike();
      #Q scl_o = 1'b1;
      #40 scl_o = 1'b0;
      #60;
   endtask
endmodule // iam_bus_master
`default_nettype wire

//--- testbench/testbench.sv
// self-checking bench for the i2c address matcher
`timescale 1ns/1ps
`default_nettype none
`include "iam_map.vh"
module testbench;
   logic core_clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic cfg_wr_i = 1'b0;
   logic [2:0] cfg_sel_i = 3'h0;
   logic [7:0] cfg_wdata_i = 8'h00;
   logic [1:0] strap_pin_low_i = 2'h0, strap_pin_mid_i = 2'h0, strap_pin_high_i = 2'h0;
   logic sda_o, sda_oe_o, read_dir_o, ctrl_ptr_vld_o, data_byte_vld_o, soft_reset_call_o, sda_low, ack;
   logic [7:0] group_call_address_reg_o, sub_call_address_first_o, sub_call_address_second_o;
   logic [7:0] sub_call_address_third_o, ctrl_ptr_o, data_byte_o;
   logic [3:0] sub_call_enables_o;
   logic [6:0] regular_addr_o;
   logic [2:0] match_kind_o;
   wire scl_i, sda_i;
   int n_fail = 0, tests_run = 0, n_soft = 0, n_ptr = 0, n_dat = 0;
   iam_addr_match i_dut (.core_clk_i, .reset_n_i, .scl_i, .sda_i, .sda_o, .sda_oe_o,
      .strap_pin_low_i, .strap_pin_mid_i, .strap_pin_high_i, .cfg_wr_i, .cfg_sel_i, .cfg_wdata_i,
      .group_call_address_reg_o, .sub_call_address_first_o, .sub_call_address_second_o,
      .sub_call_address_third_o, .sub_call_enables_o, .regular_addr_o, .match_kind_o, .read_dir_o,
      .ctrl_ptr_o, .ctrl_ptr_vld_o, .data_byte_o, .data_byte_vld_o, .soft_reset_call_o);
   iam_bus_master i_master (.scl_o(scl_i), .sda_low_o(sda_low), .sda_i);
   // wired-and data line with pull-up
   assign sda_i = ~(sda_low | (sda_oe_o & ~sda_o));
   // system clock
   always #12.5 core_clk_i = ~core_clk_i;
   // count one-cycle pulses
   always @(posedge core_clk_i) begin
      n_soft += (soft_reset_call_o === 1'b1);
      n_ptr += (ctrl_ptr_vld_o === 1'b1);
      n_dat += (data_byte_vld_o === 1'b1);
   end
   ////////////////////////////////////////////////////////////
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %0t got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("compares %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // reset only while the bus idles; straps {high,mid,low}
   task automatic do_reset(input logic [5:0] st);
      @(negedge core_clk_i);
      reset_n_i = 1'b0;
      {strap_pin_high_i, strap_pin_mid_i, strap_pin_low_i} = st;
      repeat (3) @(negedge core_clk_i);
      reset_n_i = 1'b1;
      repeat (8) @(negedge core_clk_i);
   endtask
   task automatic cfg(input logic [2:0] sel, input logic [7:0] d);
      @(negedge core_clk_i);
      cfg_wr_i = 1'b1;
      cfg_sel_i = sel;
      cfg_wdata_i = d;
      @(negedge core_clk_i);
      cfg_wr_i = 1'b0;
   endtask
   // one address frame; kind 0 means no ack expected
   task automatic xfer(input logic [7:0] a, input logic [2:0] k);
      @(negedge core_clk_i);
      i_master.start();
      i_master.send_byte(a, ack);
      check(ack, k != 3'h0);
      if (k != 3'h0) begin
         check(match_kind_o, k);
         check(read_dir_o, a[0]);
      end
      i_master.stop();
   endtask
   ////////////////////////////////////////////////////////////
   task automatic t_straps();
      logic [5:0] st [3] = '{6'h3F, 6'h0E, 6'h00};
      logic [6:0] ex [3] = '{7'h5F, 7'h1A, 7'h20};
      for (int i = 0; i < 3; i++) begin
         do_reset(st[i]);
         check({1'b0, regular_addr_o}, ex[i]);
         check(sub_call_enables_o, `IAM_EN_RST);
         xfer({ex[i], 1'b0}, 3'h1);
      end
      check(group_call_address_reg_o, 8'h90);
      check(sub_call_address_second_o, 8'h94);
      check(sub_call_address_third_o, 8'h98);
   endtask
   // default calls after reset; reserved codes kept off the table
   task automatic t_calls();
      logic [7:0] a [10] = '{8'h41, 8'h90, 8'h91, 8'h92, 8'h93, 8'h94, 8'h95, 8'h98, 8'h99, 8'h42};
      logic [2:0] k [10] = '{3'h1, 3'h2, 3'h2, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0};
      for (int i = 0; i < 10; i++)
         xfer(a[i], k[i]);
   endtask
   // reprogram, gate, then wipe the call addresses
   task automatic t_config();
      int s0;
      cfg(`IAM_SEL_EN, 8'h0E);
      cfg(3'h5, 8'h00);
      check(sub_call_enables_o, 8'h0E);
      cfg(`IAM_SEL_GROUP, 8'hA0);
      cfg(`IAM_SEL_SUB1, 8'hB0);
      cfg(`IAM_SEL_SUB2, 8'hB4);
      cfg(`IAM_SEL_SUB3, 8'hB8);
      check(group_call_address_reg_o, 8'hA0);
      check(sub_call_address_first_o, 8'hB0);
      check(sub_call_address_third_o, 8'hB8);
      xfer(8'hA0, 3'h0);
      xfer(8'hB1, 3'h3);
      xfer(8'hB5, 3'h4);
      xfer(8'hB8, 3'h5);
      cfg(`IAM_SEL_EN, 8'h01);
      xfer(8'hA1, 3'h2);
      s0 = n_soft;
      xfer(8'h07, 3'h0);
      xfer(8'h06, 3'h6);
      check(8'(n_soft - s0), 8'h01);
      check(group_call_address_reg_o, 8'h90);
      check(sub_call_address_first_o, 8'h92);
      check(sub_call_address_second_o, 8'h94);
      check(sub_call_address_third_o, 8'h98);
      check(sub_call_enables_o, `IAM_EN_RST);
   endtask
   // control byte after a spike in the low phase, then one data byte
   task automatic t_pointer();
      int p0, d0;
      p0 = n_ptr;
      d0 = n_dat;
      @(negedge core_clk_i);
      i_master.start();
      i_master.send_byte(8'h40, ack);
      i_master.spike();
      i_master.send_byte(8'h5A, ack);
      check(ack, 1'b1);
      check(ctrl_ptr_o, 8'h5A);
      check(8'(n_ptr - p0), 8'h01);
      i_master.send_byte(8'hC3, ack);
      check(data_byte_o, 8'hC3);
      check(ack, 1'b1);
      check(8'(n_dat - d0), 8'h01);
      i_master.stop();
   endtask
   initial begin
      t_straps();
      t_calls();
      t_config();
      t_pointer();
      end_of_test();
   end
   // watchdog: whole run needs well under a millisecond
   initial begin
      #1000000;
      n_fail++;
      end_of_test();
   end
endmodule // testbench
`default_nettype wire
